// *** rtl/watchdog_timers.sv ***
// Watchdog plus timers 0 to 4 behind the special-function register port
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_timers_defines.svh"
module watchdog_timers import watchdog_timers_pkg::*; #(
    parameter int WDOG_EXP_TRIM = 0,
    parameter int PMM_DIV = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic timed_access_open,
    input wire logic cpu_idle,
    input wire logic cpu_stop,
    input wire logic pmm_mode,
    input wire logic [2:0] count_pin,
    input wire logic [1:0] gate_pin,
    input wire logic [1:0] timer_isr_enter,
    output logic watchdog_reset,
    output logic watchdog_irq_flag,
    output logic watchdog_reset_flag,
    output logic [1:0] timer01_irq_req,
    output logic timer2_irq_req,
    output logic [1:0] timer34_irq_req
);
    logic [7:0] t01_ctrl_q, t01_mode_q, clk_div_q, t2_ctrl_q;
    logic [7:0] t34_ctrl_q;
    logic [7:0] t_lo_q [2];
    logic [7:0] t_hi_q [2];
    logic [15:0] t2_cnt_q, t2_rld_q;
    logic [15:0] t34_cnt_q [2];
    logic [15:0] t34_rld_q [2];
    logic [29:0] wdog_cnt_q;
    logic watchdog_reset_enable;
    logic [3:0] presc_q;
    logic [2:0] pin_q;
    logic [7:0] pmm_q;
    logic [1:0] t34_irq_q;

    function automatic logic sfr_write(input logic [7:0] a);
        return sfr_wr && (sfr_addr == a);
    endfunction

    // Shared prescaler: slow tick every 12, fast tick every 4
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            presc_q <= 4'h0;
        end else if (presc_q == 4'(`DIV_SLOW - 1)) begin
            presc_q <= 4'h0;
        end else begin
            presc_q <= presc_q + 4'h1;
        end
    end

    // (RL8) divide select; the count is an argument so that the
    // continuous assignments calling this re-evaluate as it moves
    function automatic logic tick_sel(input logic fast,
        input logic [3:0] p);
        return fast ? (p[1:0] == 2'(`DIV_FAST - 1)) :
            (p == 4'(`DIV_SLOW - 1));
    endfunction

    // (RL9) falling edge of count pins
    logic [2:0] pin_fall;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_q <= 3'h0;
        end else begin
            pin_q <= count_pin;
        end
    end
    assign pin_fall = pin_q & ~count_pin;

    // One increment step of a timer 0/1 byte pair
    function automatic tmr_step_t step(input logic [1:0] m,
        input logic [7:0] lo, input logic [7:0] hi, input logic inc);
        tmr_step_t s;
        s.ovf = 1'b0;
        s.hi = hi;
        s.lo = lo;
        if (inc) begin
            case (tmr_mode_t'(m))
                // (RL14) 13-bit mode
                MODE_13BIT: begin
                    s.lo = {lo[7:5], lo[4:0] + 5'h01};
                    if (lo[4:0] == 5'h1F) begin
                        {s.ovf, s.hi} = {1'b0, hi} + 9'h001;
                    end
                end
                // (RL15) 16-bit mode
                MODE_16BIT: begin
                    {s.ovf, s.hi, s.lo} = {1'b0, hi, lo} + 17'h00001;
                end
                // (RL16) reload from high byte
                MODE_AUTO8: begin
                    {s.ovf, s.lo} = {1'b0, lo} + 9'h001;
                    if (s.ovf) begin
                        s.lo = hi;
                    end
                end
                default: begin
                    {s.ovf, s.lo} = {1'b0, lo} + 9'h001;
                end
            endcase
        end
        return s;
    endfunction

    tmr_cfg_t cfg0, cfg1;
    logic split, run0, run1, inc0, inc1, inc0_hi, ovf0_hi;
    logic [7:0] hi0_split;
    tmr_step_t s0, s1;
    logic [1:0] t01_set;
    logic [7:0] nxt_lo [2];
    logic [7:0] nxt_hi [2];
    assign cfg0 = tmr_cfg_t'(t01_mode_q[3:0]);
    assign cfg1 = tmr_cfg_t'(t01_mode_q[7:4]);
    assign split = (tmr_mode_t'(cfg0.mode) == MODE_SPLIT);
    assign run0 = t01_ctrl_q[`B_T0_RUN];
    assign run1 = t01_ctrl_q[`B_T1_RUN];
    // (RL11) run gating (RL12) gate pin (RL13) clock source
    assign inc0 = run0 && (!cfg0.gate || gate_pin[0]) &&
        (cfg0.csel ? pin_fall[0] : tick_sel(clk_div_q[`B_T0_DIV], presc_q));
    // Timer 1 ignores its run bit while timer 0 borrows it
    assign inc1 = (split || run1) && (!cfg1.gate || gate_pin[1]) &&
        (cfg1.csel ? pin_fall[1] : tick_sel(clk_div_q[`B_T1_DIV], presc_q)) &&
        (tmr_mode_t'(cfg1.mode) != MODE_SPLIT);
    // (RL17) split high byte runs on timer 1 run bit
    assign inc0_hi = split && run1 && tick_sel(clk_div_q[`B_T0_DIV], presc_q);
    assign {ovf0_hi, hi0_split} = {1'b0, t_hi_q[0]} + {8'h00, inc0_hi};
    assign s0 = step(cfg0.mode, t_lo_q[0], t_hi_q[0], inc0);
    assign s1 = step(cfg1.mode, t_lo_q[1], t_hi_q[1], inc1);
    assign nxt_lo[0] = s0.lo;
    assign nxt_lo[1] = s1.lo;
    assign nxt_hi[0] = split ? hi0_split : s0.hi;
    assign nxt_hi[1] = s1.hi;
    assign t01_set[0] = s0.ovf;
    // (RL17) split high byte raises timer 1 flag
    assign t01_set[1] = split ? ovf0_hi : s1.ovf;

    localparam logic [7:0] LO_ADDR [2] = '{`ADDR_T0_LO, `ADDR_T1_LO};
    localparam logic [7:0] HI_ADDR [2] = '{`ADDR_T0_HI, `ADDR_T1_HI};
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                t_lo_q[i] <= `RST_ZERO;
                t_hi_q[i] <= `RST_ZERO;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                t_lo_q[i] <= sfr_write(LO_ADDR[i]) ? sfr_wdata : nxt_lo[i];
                t_hi_q[i] <= sfr_write(HI_ADDR[i]) ? sfr_wdata : nxt_hi[i];
            end
        end
    end

    // Flags: overflow set beats both software and service clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t01_ctrl_q <= `RST_ZERO;
        end else begin
            if (sfr_write(`ADDR_T01_CTRL)) begin
                t01_ctrl_q <= sfr_wdata;
            end
            // (RL10) set on overflow, clear on service
            t01_ctrl_q[`B_T0_FLAG] <= t01_set[0] ||
                (sfr_write(`ADDR_T01_CTRL) ? sfr_wdata[`B_T0_FLAG] :
                 t01_ctrl_q[`B_T0_FLAG] && !timer_isr_enter[0]);
            t01_ctrl_q[`B_T1_FLAG] <= t01_set[1] ||
                (sfr_write(`ADDR_T01_CTRL) ? sfr_wdata[`B_T1_FLAG] :
                 t01_ctrl_q[`B_T1_FLAG] && !timer_isr_enter[1]);
        end
    end
    assign timer01_irq_req = {t01_ctrl_q[`B_T1_FLAG],
        t01_ctrl_q[`B_T0_FLAG]};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t01_mode_q <= `RST_ZERO;
            clk_div_q <= `RST_CLK_DIV;
        end else begin
            if (sfr_write(`ADDR_T01_MODE)) begin
                t01_mode_q <= sfr_wdata;
            end
            if (sfr_write(`ADDR_CLK_DIV)) begin
                clk_div_q <= sfr_wdata;
            end
        end
    end

    // Timer 2: 16-bit counter with its own reload register
    logic t2_inc, t2_ovf;
    assign t2_inc = t2_ctrl_q[`B_T2_RUN] && (t2_ctrl_q[`B_T2_CSEL] ?
        pin_fall[2] : tick_sel(clk_div_q[`B_T2_DIV], presc_q));
    assign t2_ovf = t2_inc && (t2_cnt_q == 16'hFFFF);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t2_cnt_q <= 16'h0000;
            t2_rld_q <= 16'h0000;
        end else begin
            // (RL18) run bit counts (RL25) reload on overflow
            if (t2_ovf) begin
                t2_cnt_q <= t2_rld_q;
            end else if (t2_inc) begin
                t2_cnt_q <= t2_cnt_q + 16'h0001;
            end
            if (sfr_write(`ADDR_T2_LO)) begin
                t2_cnt_q[7:0] <= sfr_wdata;
            end
            if (sfr_write(`ADDR_T2_HI)) begin
                t2_cnt_q[15:8] <= sfr_wdata;
            end
            if (sfr_write(`ADDR_T2_RLD_LO)) begin
                t2_rld_q[7:0] <= sfr_wdata;
            end
            if (sfr_write(`ADDR_T2_RLD_HI)) begin
                t2_rld_q[15:8] <= sfr_wdata;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t2_ctrl_q <= `RST_ZERO;
        end else begin
            if (sfr_write(`ADDR_T2_CTRL)) begin
                t2_ctrl_q[`B_T2_RUN] <= sfr_wdata[`B_T2_RUN];
                t2_ctrl_q[`B_T2_CSEL] <= sfr_wdata[`B_T2_CSEL];
            end
            // (RL18) sticky flag, software clears
            t2_ctrl_q[`B_T2_FLAG] <= t2_ovf ||
                (sfr_write(`ADDR_T2_CTRL) ? sfr_wdata[`B_T2_FLAG] :
                 t2_ctrl_q[`B_T2_FLAG]);
        end
    end
    assign timer2_irq_req = t2_ctrl_q[`B_T2_FLAG];

    // Timers 3 and 4 share one layout, one control nibble each
    localparam logic [7:0] T34_LO [2] = '{`ADDR_T3_LO, `ADDR_T4_LO};
    localparam logic [7:0] T34_HI [2] = '{`ADDR_T3_HI, `ADDR_T4_HI};
    logic [1:0] t34_run, t34_mode, t34_ovf, t34_ien, t34_flag;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_t34
            assign t34_run[g] = t34_ctrl_q[g*4 + `B_N_RUN];
            assign t34_mode[g] = t34_ctrl_q[g*4 + `B_N_MODE];
            assign t34_ien[g] = t34_ctrl_q[g*4 + `B_N_IEN];
            assign t34_flag[g] = t34_ctrl_q[g*4 + `B_N_FLAG];
            assign t34_ovf[g] = t34_run[g] && (t34_cnt_q[g] == 16'hFFFF);
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                t34_cnt_q[i] <= 16'h0000;
                t34_rld_q[i] <= 16'h0000;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                // (RL21) reload or wrap, one count per clock
                if (t34_ovf[i]) begin
                    t34_cnt_q[i] <= t34_mode[i] ? t34_rld_q[i] : 16'h0000;
                end else if (t34_run[i]) begin
                    t34_cnt_q[i] <= t34_cnt_q[i] + 16'h0001;
                end
                // (RL23) reload mode writes reload, free-run the count
                if (sfr_write(T34_LO[i])) begin
                    if (t34_mode[i]) begin
                        t34_rld_q[i][7:0] <= sfr_wdata;
                    end else begin
                        t34_cnt_q[i][7:0] <= sfr_wdata;
                    end
                end
                if (sfr_write(T34_HI[i])) begin
                    if (t34_mode[i]) begin
                        t34_rld_q[i][15:8] <= sfr_wdata;
                    end else begin
                        t34_cnt_q[i][15:8] <= sfr_wdata;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            t34_ctrl_q <= `RST_ZERO;
            t34_irq_q <= 2'h0;
        end else begin
            if (sfr_write(`ADDR_T34_CTRL)) begin
                t34_ctrl_q <= sfr_wdata;
            end
            for (int i = 0; i < 2; i++) begin
                // (RL20) overflow sets flag, wins over clear
                t34_ctrl_q[i*4 + `B_N_FLAG] <= t34_ovf[i] ||
                    (sfr_write(`ADDR_T34_CTRL) ?
                     sfr_wdata[i*4 + `B_N_FLAG] : t34_flag[i]);
                // (RL22) enable gates request
                t34_irq_q[i] <= t34_flag[i] && t34_ien[i];
            end
        end
    end
    assign timer34_irq_req = t34_irq_q;

    // Watchdog: halts with the CPU clock, slowed in PMM
    logic pmm_tick, wdog_step, wdog_hit, wdog_restart;
    logic [2:0] wdog_sel;
    logic [29:0] wdog_last;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pmm_q <= 8'h00;
        end else if (pmm_q == 8'(PMM_DIV - 1)) begin
            pmm_q <= 8'h00;
        end else begin
            pmm_q <= pmm_q + 8'h01;
        end
    end
    assign pmm_tick = (pmm_q == 8'(PMM_DIV - 1));
    // (RL24) stops in idle and stop
    assign wdog_step = !cpu_idle && !cpu_stop && (!pmm_mode || pmm_tick);

    // (RL6) timeout table, trim shortens it for simulation
    function automatic logic [29:0] wdog_period(input logic [2:0] s);
        int e;
        logic [30:0] p;
        case (s)
            3'h0: e = `WDOG_EXP0;
            3'h1: e = `WDOG_EXP1;
            3'h2: e = `WDOG_EXP2;
            3'h3: e = `WDOG_EXP3;
            3'h4: e = `WDOG_EXP4;
            3'h5: e = `WDOG_EXP5;
            3'h6: e = `WDOG_EXP6;
            default: e = `WDOG_EXP7;
        endcase
        p = 31'h00000001 << (e - WDOG_EXP_TRIM);
        return 30'(p - 31'h00000001);
    endfunction
    assign wdog_sel = {clk_div_q[`B_SEL2], clk_div_q[`B_SEL1],
        clk_div_q[`B_SEL0]};
    assign wdog_last = wdog_period(wdog_sel);
    assign wdog_hit = wdog_step && (wdog_cnt_q == wdog_last);
    // (RL5) restart only with timed access open
    assign wdog_restart = sfr_wr && (sfr_addr == `ADDR_WDOG_CTRL) &&
        sfr_wdata[`B_WDOG_RESTART] && timed_access_open;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdog_cnt_q <= 30'h00000000;
        end else if (wdog_restart || wdog_hit) begin
            // (RL4) restart clears (RL26) timeout restarts
            wdog_cnt_q <= 30'h00000000;
        end else if (wdog_step) begin
            wdog_cnt_q <= wdog_cnt_q + 30'h00000001;
        end
    end

    // Reset flag is cleared by this block's own reset input or by a software write of zero
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            watchdog_irq_flag <= 1'b0;
            watchdog_reset_flag <= 1'b0;
            watchdog_reset_enable <= 1'b0;
            watchdog_reset <= 1'b0;
        end else begin
            // (RL1) timeout sets flag regardless of enable
            watchdog_irq_flag <= wdog_hit ||
                (sfr_write(`ADDR_WDOG_CTRL) ? sfr_wdata[`B_WDOG_IRQF] :
                 watchdog_irq_flag);
            // (RL2) set by watchdog reset, software may clear
            watchdog_reset_flag <= (wdog_hit && watchdog_reset_enable) ||
                (sfr_write(`ADDR_WDOG_CTRL) ? sfr_wdata[`B_WDOG_RSTF] :
                 watchdog_reset_flag);
            if (sfr_write(`ADDR_WDOG_CTRL)) begin
                watchdog_reset_enable <= sfr_wdata[`B_WDOG_RSTEN];
            end
            // (RL3) reset only when enabled (RL26) one-cycle pulse
            watchdog_reset <= wdog_hit && watchdog_reset_enable;
        end
    end

    // Read data: live counts, registered one cycle after the address
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (sfr_addr == `ADDR_T01_CTRL) begin
            rd_mux = t01_ctrl_q;
        end else if (sfr_addr == `ADDR_T01_MODE) begin
            rd_mux = t01_mode_q;
        end else if (sfr_addr == `ADDR_T0_LO) begin
            rd_mux = t_lo_q[0];
        end else if (sfr_addr == `ADDR_T1_LO) begin
            rd_mux = t_lo_q[1];
        end else if (sfr_addr == `ADDR_T0_HI) begin
            rd_mux = t_hi_q[0];
        end else if (sfr_addr == `ADDR_T1_HI) begin
            rd_mux = t_hi_q[1];
        end else if (sfr_addr == `ADDR_WDOG_CTRL) begin
            // (RL4) restart bit reads zero
            rd_mux = {4'h0, watchdog_irq_flag, watchdog_reset_flag,
                watchdog_reset_enable, 1'b0};
        end else if (sfr_addr == `ADDR_CLK_DIV) begin
            rd_mux = clk_div_q;
        end else if (sfr_addr == `ADDR_T2_CTRL) begin
            rd_mux = t2_ctrl_q;
        end else if (sfr_addr == `ADDR_T2_LO) begin
            rd_mux = t2_cnt_q[7:0];
        end else if (sfr_addr == `ADDR_T2_HI) begin
            rd_mux = t2_cnt_q[15:8];
        end else if (sfr_addr == `ADDR_T2_RLD_LO) begin
            rd_mux = t2_rld_q[7:0];
        end else if (sfr_addr == `ADDR_T2_RLD_HI) begin
            rd_mux = t2_rld_q[15:8];
        end else if (sfr_addr == `ADDR_T34_CTRL) begin
            rd_mux = t34_ctrl_q;
        end else if (sfr_addr == `ADDR_T3_LO) begin
            rd_mux = t34_cnt_q[0][7:0];
        end else if (sfr_addr == `ADDR_T3_HI) begin
            rd_mux = t34_cnt_q[0][15:8];
        end else if (sfr_addr == `ADDR_T4_LO) begin
            rd_mux = t34_cnt_q[1][7:0];
        end else if (sfr_addr == `ADDR_T4_HI) begin
            rd_mux = t34_cnt_q[1][15:8];
        end
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= rd_mux;
        end
    end

    chk_wdog_irq_set: assert property (@(posedge core_clk) disable iff (rst) // RL1
        wdog_hit |=> watchdog_irq_flag && wdog_cnt_q == 30'h0)
        else $error("watchdog timeout did not set flag");
    chk_wdog_rst_pulse: assert property (@(posedge core_clk) disable iff (rst) // RL3
        watchdog_reset |-> $past(wdog_hit) && $past(watchdog_reset_enable)
        ##1 !watchdog_reset)
        else $error("watchdog reset pulse wrong");
    chk_wdog_restart: assert property (@(posedge core_clk) disable iff (rst) // RL4
        wdog_restart |=> wdog_cnt_q == 30'h0)
        else $error("restart did not clear watchdog");
    chk_wdog_locked: assert property (@(posedge core_clk) disable iff (rst) // RL5
        sfr_write(`ADDR_WDOG_CTRL) && !timed_access_open && wdog_step &&
        !wdog_hit |=> wdog_cnt_q == $past(wdog_cnt_q) + 30'h1)
        else $error("locked restart was honoured");
    chk_t0_hold: assert property (@(posedge core_clk) disable iff (rst) // RL11
        !run0 && !sfr_write(`ADDR_T0_LO) |=> $stable(t_lo_q[0]))
        else $error("timer 0 moved while stopped");
    chk_t0_reload: assert property (@(posedge core_clk) disable iff (rst) // RL16
        cfg0.mode == 2'(MODE_AUTO8) && s0.ovf && !sfr_wr
        |=> t_lo_q[0] == $past(t_hi_q[0]) && t01_ctrl_q[`B_T0_FLAG])
        else $error("timer 0 mode 2 reload wrong");
    chk_t2_reload: assert property (@(posedge core_clk) disable iff (rst) // RL25
        t2_ovf && !sfr_wr |=> t2_cnt_q == $past(t2_rld_q) &&
        t2_ctrl_q[`B_T2_FLAG])
        else $error("timer 2 reload wrong");
    chk_t3_flag: assert property (@(posedge core_clk) disable iff (rst) // RL20
        t34_ovf[0] |=> t34_flag[0] ##1 t34_irq_q[0] == t34_ien[0])
        else $error("timer 3 flag or request wrong");
    chk_t4_irq: assert property (@(posedge core_clk) disable iff (rst) // RL22
        t34_irq_q[1] |-> $past(t34_flag[1]) && $past(t34_ien[1]))
        else $error("timer 4 request without enable");
endmodule // watchdog_timers
`default_nettype wire

// *** rtl/watchdog_timers_defines.svh ***
// Register map, field positions and counts of the watchdog and timers
// Summary of operation
// (RL1) Timeout always sets watchdog interrupt flag
// (RL2) Reset flag set by watchdog reset only; the code also sets it on a software write of one
// (RL3) Timeout resets system only when enabled
// (RL4) Restart write clears count, reads zero
// (RL5) Restart honoured only with timed access open
// (RL6) Timeout select picks one of eight periods
// (RL7) Software clears interrupt flag; enable lives elsewhere
// (RL8) Divide bit picks clock over 4 or 12
// (RL9) Counter mode counts external falling edges
// (RL10) Timer 0/1 flags clear on service entry
// (RL11) Timer 0/1 count only while run set; the code runs timer 1 without its run bit while timer 0 is in mode 3
// (RL12) Gate bit adds external gate input
// (RL13) Select bit picks pin or divided clock
// (RL14) Mode 0 is 5-bit prescaler plus 8-bit
// (RL15) Mode 1 is one 16-bit counter
// (RL16) Mode 2 low byte reloads from high
// (RL17) Mode 3 splits timer 0 in two
// (RL18) Timer 2 run bit enables auto-reload counter
// (RL19) Software keeps timer 2 select bit zero
// (RL20) Timer 3/4 flags set on overflow, sticky
// (RL21) Timer 3/4 16-bit, reload or free-run
// (RL22) Enable bit forwards timer 3/4 request
// (RL23) Writes hit reload or count; reads live
// (RL24) Watchdog 30-bit, halts idle, slows PMM
// (RL25) Timer 2 reloads from reload register
// (RL26) Watchdog reset is one-cycle pulse, restart
`ifndef WATCHDOG_TIMERS_DEFINES_SVH
`define WATCHDOG_TIMERS_DEFINES_SVH
`define ADDR_T01_CTRL 8'h88
`define ADDR_T01_MODE 8'h89
`define ADDR_T0_LO 8'h8A
`define ADDR_T1_LO 8'h8B
`define ADDR_T0_HI 8'h8C
`define ADDR_T1_HI 8'h86
`define ADDR_WDOG_CTRL 8'h8D
`define ADDR_CLK_DIV 8'h8E
`define ADDR_T4_LO 8'hAC
`define ADDR_T4_HI 8'hAD
`define ADDR_T3_LO 8'hAE
`define ADDR_T3_HI 8'hAF
`define ADDR_T2_CTRL 8'hC8
`define ADDR_T2_RLD_LO 8'hCA
`define ADDR_T2_RLD_HI 8'hCB
`define ADDR_T2_LO 8'hCC
`define ADDR_T2_HI 8'hCD
`define ADDR_T34_CTRL 8'hCF
`define RST_CLK_DIV 8'hC7
`define RST_ZERO 8'h00
`define B_T1_FLAG 7
`define B_T1_RUN 6
`define B_T0_FLAG 5
`define B_T0_RUN 4
`define B_WDOG_IRQF 3
`define B_WDOG_RSTF 2
`define B_WDOG_RSTEN 1
`define B_WDOG_RESTART 0
`define B_SEL2 2
`define B_SEL1 7
`define B_SEL0 6
`define B_T0_DIV 3
`define B_T1_DIV 4
`define B_T2_DIV 5
`define B_T2_FLAG 7
`define B_T2_RUN 2
`define B_T2_CSEL 1
`define B_N_FLAG 3
`define B_N_MODE 2
`define B_N_RUN 1
`define B_N_IEN 0
`define DIV_SLOW 12
`define DIV_FAST 4
`define WDOG_EXP0 17
`define WDOG_EXP1 20
`define WDOG_EXP2 23
`define WDOG_EXP3 26
`define WDOG_EXP4 27
`define WDOG_EXP5 28
`define WDOG_EXP6 29
`define WDOG_EXP7 30
`endif

// *** rtl/watchdog_timers_pkg.sv ***
// Types shared by the watchdog and timer block
package watchdog_timers_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT = 2'h0,
        MODE_16BIT = 2'h1,
        MODE_AUTO8 = 2'h2,
        MODE_SPLIT = 2'h3
    } tmr_mode_t;
    // Matches one nibble of the timer 0/1 mode register
    typedef struct packed {
        logic gate;
        logic csel;
        logic [1:0] mode;
    } tmr_cfg_t;
    typedef struct packed {
        logic ovf;
        logic [7:0] hi;
        logic [7:0] lo;
    } tmr_step_t;
endpackage

// *** tb/tb_watchdog_timers.sv ***
// Register-level testbench for the watchdog and timer block
`timescale 1ns/1ps
`default_nettype none
`include "watchdog_timers_defines.svh"
module tb_watchdog_timers;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic timed_access_open = 1'b0;
    logic cpu_idle = 1'b0;
    logic cpu_stop = 1'b0;
    logic pmm_mode = 1'b0;
    logic [2:0] count_pin = 3'h7;
    logic [1:0] gate_pin = 2'h0;
    logic [1:0] timer_isr_enter = 2'h0;
    logic [7:0] sfr_rdata;
    logic watchdog_reset;
    logic watchdog_irq_flag;
    logic watchdog_reset_flag;
    logic [1:0] timer01_irq_req;
    logic timer2_irq_req;
    logic [1:0] timer34_irq_req;
    int miscompares = 0;
    int n_checks = 0;
    int pulses = 0;
    logic [7:0] v;

    always #50 core_clk = ~core_clk;

    // Trim 15 shortens timeout select 000 to a period of 4 clocks
    watchdog_timers #(.WDOG_EXP_TRIM(15)) dut (.core_clk(core_clk),
        .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .timed_access_open(timed_access_open), .cpu_idle(cpu_idle),
        .cpu_stop(cpu_stop), .pmm_mode(pmm_mode), .count_pin(count_pin),
        .gate_pin(gate_pin), .timer_isr_enter(timer_isr_enter),
        .watchdog_reset(watchdog_reset),
        .watchdog_irq_flag(watchdog_irq_flag),
        .watchdog_reset_flag(watchdog_reset_flag),
        .timer01_irq_req(timer01_irq_req), .timer2_irq_req(timer2_irq_req),
        .timer34_irq_req(timer34_irq_req));

    always @(posedge core_clk) if (watchdog_reset === 1'b1) pulses++;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge core_clk);
        sfr_wr = 1'b0;
    endtask

    // Read data is registered, so it is valid one cycle after the address
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk);
        sfr_addr = a;
        @(negedge core_clk);
        d = sfr_rdata;
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        #400000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (3) @(negedge core_clk);
        rst = 1'b0;
        rd(`ADDR_CLK_DIV, v);
        chk(v, `RST_CLK_DIV);
        rd(`ADDR_WDOG_CTRL, v);
        chk(v, `RST_ZERO);
        // Free-run writes land in the count directly
        wr(`ADDR_T3_HI, 8'hFF);
        wr(`ADDR_T3_LO, 8'hFE);
        wr(`ADDR_T4_HI, 8'hFF);
        wr(`ADDR_T4_LO, 8'hFE);
        // Reload mode writes go to the reload register, reads stay live
        wr(`ADDR_T34_CTRL, 8'h40);
        wr(`ADDR_T4_LO, 8'h34);
        wr(`ADDR_T4_HI, 8'h12);
        rd(`ADDR_T4_LO, v);
        chk(v, 8'hFE);
        wr(`ADDR_T34_CTRL, 8'h73);
        repeat (4) @(negedge core_clk);
        rd(`ADDR_T34_CTRL, v);
        chk(v, 8'hFB);
        rd(`ADDR_T4_HI, v);
        chk(v, 8'h12);
        chk({6'h0, timer34_irq_req}, 8'h03);
        wr(`ADDR_T34_CTRL, 8'h02);
        repeat (3) @(negedge core_clk);
        chk({6'h0, timer34_irq_req}, 8'h00);
        // Timer 2 on the fast tick overflows into its reload value
        wr(`ADDR_T2_RLD_HI, 8'h12);
        wr(`ADDR_T2_HI, 8'hFF);
        wr(`ADDR_T2_LO, 8'hFF);
        wr(`ADDR_CLK_DIV, 8'h20);
        wr(`ADDR_T2_CTRL, 8'h04);
        repeat (6) @(negedge core_clk);
        rd(`ADDR_T2_HI, v);
        chk(v, 8'h12);
        chk({7'h0, timer2_irq_req}, 8'h01);
        wr(`ADDR_T2_CTRL, 8'h00);
        chk({7'h0, timer2_irq_req}, 8'h00);
        // Timer 0 counting three falling edges of its pin in mode 1
        wr(`ADDR_T01_MODE, 8'h05);
        wr(`ADDR_T01_CTRL, 8'h10);
        repeat (3) begin
            @(negedge core_clk) count_pin[0] = 1'b0;
            @(negedge core_clk) count_pin[0] = 1'b1;
        end
        rd(`ADDR_T0_LO, v);
        chk(v, 8'h03);
        // Mode 2: low byte overflows and reloads from the high byte
        wr(`ADDR_T01_MODE, 8'h06);
        wr(`ADDR_T0_HI, 8'hFE);
        wr(`ADDR_T0_LO, 8'hFF);
        @(negedge core_clk) count_pin[0] = 1'b0;
        @(negedge core_clk) count_pin[0] = 1'b1;
        rd(`ADDR_T0_LO, v);
        chk(v, 8'hFE);
        chk({6'h0, timer01_irq_req}, 8'h01);
        @(negedge core_clk) timer_isr_enter[0] = 1'b1;
        @(negedge core_clk) timer_isr_enter[0] = 1'b0;
        chk({6'h0, timer01_irq_req}, 8'h00);
        // Watchdog timeout without reset enable raises only the flag
        timed_access_open = 1'b1;
        wr(`ADDR_CLK_DIV, 8'h00);
        wr(`ADDR_WDOG_CTRL, 8'h01);
        for (int i = 0; i < 10 && watchdog_irq_flag !== 1'b1; i++)
            @(negedge core_clk);
        chk({7'h0, watchdog_irq_flag}, 8'h01);
        chk(pulses[7:0], 8'h00);
        wr(`ADDR_WDOG_CTRL, 8'h02);
        for (int i = 0; i < 10 && pulses == 0; i++)
            @(negedge core_clk);
        chk(pulses[7:0], 8'h01);
        chk({7'h0, watchdog_reset_flag}, 8'h01);
        // Locked restarts are ignored, so timeouts keep coming
        timed_access_open = 1'b0;
        repeat (6) wr(`ADDR_WDOG_CTRL, 8'h03);
        chk({7'h0, pulses > 2}, 8'h01);
        // Idle holds the count, so no new timeout may appear
        cpu_idle = 1'b1;
        wr(`ADDR_WDOG_CTRL, 8'h00);
        repeat (20) @(negedge core_clk);
        chk({7'h0, watchdog_reset_flag}, 8'h00);
        chk({7'h0, watchdog_irq_flag}, 8'h00);
        cpu_idle = 1'b0;
        cpu_stop = 1'b1;
        repeat (20) @(negedge core_clk);
        chk({7'h0, watchdog_irq_flag}, 8'h00);
        // Slowed rate: four steps of the period span 25 to 32 clocks
        timed_access_open = 1'b1;
        pmm_mode = 1'b1;
        wr(`ADDR_WDOG_CTRL, 8'h01);
        cpu_stop = 1'b0;
        repeat (20) @(negedge core_clk);
        chk({7'h0, watchdog_irq_flag}, 8'h00);
        for (int i = 0; i < 20 && watchdog_irq_flag !== 1'b1; i++)
            @(negedge core_clk);
        chk({7'h0, watchdog_irq_flag}, 8'h01);
        report_and_stop();
    end
endmodule // tb_watchdog_timers
`default_nettype wire
